// *** src/mgis_defines.svh ***
// Constants for the main gate and input selector block.
// Assumes inclusion by bare name from the design files under src/.
`ifndef MGIS_DEFINES_SVH
`define MGIS_DEFINES_SVH

// Gate flip-flop preset level (gate closed)
`define MGIS_GATE_RST_VAL 1'b1
// First binary stage division
`define MGIS_BINARY_DIV 2
// Decade stage division
`define MGIS_DECADE_DIV 10
// Default width of the accumulated counts
`define MGIS_CNT_W 32
// Nominal timebase rate in MHz, seen here as a sampled level input
`define MGIS_TIMEBASE_MHZ 500

`endif

// *** src/mgis_pkg.sv ***
// Types used by the main gate only; its scaler stages use none of them.
// Assumes nothing beyond a SystemVerilog compiler.
package mgis_pkg;

    // Measurement phase of the gate pair
    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_ARMED   = 6'h02,
        ST_MEASURE = 6'h04,
        ST_CLOSE   = 6'h08,
        ST_LATCH   = 6'h10,
        ST_DONE    = 6'h20
    } mgis_state_t;

endpackage

// *** src/mgis_scaler_if.sv ***
// Link between the main gate and one scaler front stage.
// Assumes both ends run on the same clock.
interface mgis_scaler_if #(
    parameter int CNT_W = 32
);
    logic clr;
    logic hold;
    logic c1_pulse;
    logic c2_pulse;
    logic c2_en;
    logic div_pulse;
    logic [CNT_W-1:0] count;

    // Gate side drives the controls
    modport ctl (
        output clr,
        output hold,
        output c1_pulse,
        output c2_pulse,
        output c2_en,
        input div_pulse,
        input count
    );

    // Scaler side answers with divided pulse and total
    modport stage (
        input clr,
        input hold,
        input c1_pulse,
        input c2_pulse,
        input c2_en,
        output div_pulse,
        output count
    );
endinterface

// *** src/mgis_scaler.sv ***
// Scaler front stage: a divide-by-two binary, a decade and a running total.
// Assumes one-cycle input pulses on clk and the gate driving hold.
`include "mgis_defines.svh"

module mgis_scaler #(
    parameter int CNT_W = `MGIS_CNT_W,
    parameter int DECADE = `MGIS_DECADE_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Gate link
    mgis_scaler_if.stage sif
);

    logic binary_ff;
    logic [3:0] decade_ff;
    logic div_ff;
    logic [CNT_W-1:0] count_ff;
    logic in_pulse;
    logic carry;

    // Hold blocks the first clock input only; second input has its own enable
    assign in_pulse = (sif.c1_pulse & ~sif.hold) | (sif.c2_pulse & sif.c2_en); // RULE7 RULE8
    // Binary passes a carry on its falling half
    assign carry = in_pulse & binary_ff; // RULE14

    // Binary stage, inactive while cleared; hold stops first-input pulses only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            binary_ff <= 1'b0;
        end else if (sif.clr) begin
            binary_ff <= 1'b0;
        end else if (in_pulse) begin
            binary_ff <= ~binary_ff; // RULE14
        end
    end

    // Decade stage, one output pulse each ten carries
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            decade_ff <= 4'h0;
            div_ff <= 1'b0;
        end else if (sif.clr) begin
            decade_ff <= 4'h0;
            div_ff <= 1'b0;
        end else begin
            div_ff <= 1'b0;
            if (carry) begin
                if (decade_ff == 4'(DECADE - 1)) begin
                    decade_ff <= 4'h0;
                    div_ff <= 1'b1; // RULE14
                end else begin
                    decade_ff <= decade_ff + 4'h1;
                end
            end
        end
    end

    // Running total of pulses let through
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
        end else if (sif.clr) begin
            count_ff <= '0;
        end else if (in_pulse) begin
            count_ff <= count_ff + CNT_W'(1); // RULE9
        end
    end

    assign sif.div_pulse = div_ff;
    assign sif.count = count_ff;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_decade_wrap: assert property (carry && decade_ff == 4'(DECADE - 1) && !sif.clr |=> div_ff) // RULE14
        else $error("decade did not emit on wrap");
    c_decade_out: cover property (div_ff);

endmodule // mgis_scaler

// *** src/mgis_main_gate.sv ***
// Main gate with input selector, gate flip-flops and turn-off control.
// Assumes inputs synchronous to clk; timebase arrives as a sampled level.
`include "mgis_defines.svh"

// Overview of operation
// RULE1: Only the signals the selected measurement needs reach the gates; all others are blocked.
// RULE2: In frequency or period mode channel A is routed to the event gate clock.
// RULE3: In frequency or period mode channel B may pass its multiplexer but never reaches a gate.
// RULE4: In frequency or period mode the timebase clocks the time gate.
// RULE5: Gate reset presets both gate flip-flops high before a measurement.
// RULE6: The time gate stays high while the event gate and its steering term are high.
// RULE7: While the gates are high the first binary of each scaler is held and does not count.
// RULE8: With interval-or-events low the input reaches the event binary second input, which stays disabled.
// RULE9: The scalers count events and timebase pulses and deliver totals when the gate closes.
// RULE10: Turn-off control switches the timebase and channels A and B on or off.
// RULE11: The controller encodes the mode on the ratio and interval select lines.
// RULE12: After arm rises the next input opens the event gate, the next timebase edge the time gate.
// RULE13: After arm falls the next input closes the event gate, the next timebase edge the time gate.
// RULE14: Each scaler divides by two in its binary and by ten in the following decade.
// RULE15: The time gate changes only on timebase edges so whole cycles are counted.
// RULE16: The controller resets the gates before arming and keeps the mode lines stable.
module mgis_main_gate #(
    parameter int CNT_W = `MGIS_CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Mode control
    input wire logic ratio_or_totalize_select,
    input wire logic interval_or_events_select,
    input wire logic external_ab_input_select,
    input wire logic external_c_select,
    // Gate control
    input wire logic gate_arm,
    input wire logic gate_rst,
    // Measured signals and timebase
    input wire logic channel_a_input_signal,
    input wire logic channel_b_input_signal,
    input wire logic timebase_in,
    // Gate state, high means closed
    output logic event_gate_ff,
    output logic time_gate_ff,
    // Divide-by-twenty outputs to later stages
    output logic event_div_ff,
    output logic time_div_ff,
    // Accumulated results
    output logic [CNT_W-1:0] event_count_ff,
    output logic [CNT_W-1:0] time_count_ff,
    output logic count_valid_ff,
    // Turn-off status and channel B multiplexer output
    output logic timebase_on_ff,
    output logic channels_on_ff,
    output logic chb_mux_ff
);

    mgis_pkg::mgis_state_t state_ff;
    mgis_pkg::mgis_state_t nxt_state;

    logic a_prev_ff;
    logic b_prev_ff;
    logic tb_prev_ff;
    logic freq_mode;
    logic evt_pulse;
    logic tb_pulse;
    logic chb_edge;

    mgis_scaler_if #(.CNT_W(CNT_W)) evt_sif ();
    mgis_scaler_if #(.CNT_W(CNT_W)) tim_sif ();

    // Rising edges of the measured inputs and timebase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_prev_ff <= 1'b0;
            b_prev_ff <= 1'b0;
            tb_prev_ff <= 1'b0;
        end else begin
            a_prev_ff <= channel_a_input_signal;
            b_prev_ff <= channel_b_input_signal;
            tb_prev_ff <= timebase_in;
        end
    end

    // Both select lines low means frequency or period
    assign freq_mode = ~ratio_or_totalize_select & ~interval_or_events_select; // RULE11

    // Channel A is the only event source in this mode
    assign evt_pulse = channel_a_input_signal & ~a_prev_ff & channels_on_ff & freq_mode; // RULE1 RULE2
    // Timebase feeds only the time side: time gate clock, time scaler and closing phase
    assign tb_pulse = timebase_in & ~tb_prev_ff & timebase_on_ff & freq_mode; // RULE4
    // Channel B reaches its multiplexer only; no gate path exists for it here
    assign chb_edge = channel_b_input_signal & ~b_prev_ff & channels_on_ff; // RULE3

    // Turn-off control, registered so gating uses stable levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timebase_on_ff <= 1'b0;
            channels_on_ff <= 1'b0;
            chb_mux_ff <= 1'b0;
        end else begin
            timebase_on_ff <= ~ratio_or_totalize_select & ~external_c_select; // RULE10
            channels_on_ff <= ~external_ab_input_select; // RULE10
            chb_mux_ff <= chb_edge; // RULE3
        end
    end

    // Measurement phase sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            mgis_pkg::ST_IDLE: begin
                if (gate_arm) begin
                    nxt_state = mgis_pkg::ST_ARMED;
                end
            end
            mgis_pkg::ST_ARMED: begin
                if (evt_pulse && gate_arm) begin
                    nxt_state = mgis_pkg::ST_MEASURE;
                end
            end
            mgis_pkg::ST_MEASURE: begin
                if (evt_pulse && !gate_arm) begin
                    nxt_state = mgis_pkg::ST_CLOSE;
                end
            end
            mgis_pkg::ST_CLOSE: begin
                if (tb_pulse) begin
                    nxt_state = mgis_pkg::ST_LATCH;
                end
            end
            mgis_pkg::ST_LATCH: begin
                nxt_state = mgis_pkg::ST_DONE;
            end
            mgis_pkg::ST_DONE: begin
                nxt_state = mgis_pkg::ST_DONE;
            end
        endcase
    end

    // Gate reset restarts the sequence from any phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= mgis_pkg::ST_IDLE;
        end else if (gate_rst) begin
            state_ff <= mgis_pkg::ST_IDLE; // RULE5
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Event gate: preset closed by gate reset, else opened and closed only by channel A pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_gate_ff <= `MGIS_GATE_RST_VAL;
        end else if (gate_rst) begin
            event_gate_ff <= `MGIS_GATE_RST_VAL; // RULE5
        end else if (evt_pulse) begin
            if (state_ff == mgis_pkg::ST_ARMED && gate_arm) begin
                event_gate_ff <= 1'b0; // RULE12
            end else if (state_ff == mgis_pkg::ST_MEASURE && !gate_arm) begin
                event_gate_ff <= 1'b1; // RULE13
            end
        end
    end

    // Time gate follows the event gate one timebase edge later,
    // so the time scaler never sees a partial cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            time_gate_ff <= `MGIS_GATE_RST_VAL;
        end else if (gate_rst) begin
            time_gate_ff <= `MGIS_GATE_RST_VAL; // RULE5
        end else if (tb_pulse) begin
            time_gate_ff <= event_gate_ff; // RULE6 RULE12 RULE13 RULE15
        end
    end

    // Event scaler: counts channel A only while its gate is low
    assign evt_sif.clr = gate_rst;
    assign evt_sif.hold = event_gate_ff; // RULE7
    assign evt_sif.c1_pulse = evt_pulse; // RULE9
    // Second input sees the signal but stays off unless interval mode is selected
    assign evt_sif.c2_pulse = evt_pulse; // RULE8
    assign evt_sif.c2_en = interval_or_events_select; // RULE8

    // Time scaler: counts timebase only while its gate is low
    assign tim_sif.clr = gate_rst;
    assign tim_sif.hold = time_gate_ff; // RULE7
    assign tim_sif.c1_pulse = tb_pulse; // RULE9
    assign tim_sif.c2_pulse = 1'b0;
    assign tim_sif.c2_en = 1'b0;

    mgis_scaler #(.CNT_W(CNT_W), .DECADE(`MGIS_DECADE_DIV)) u_evt_scaler (
        .clk(clk),
        .rst(rst),
        .sif(evt_sif)
    );

    mgis_scaler #(.CNT_W(CNT_W), .DECADE(`MGIS_DECADE_DIV)) u_tim_scaler (
        .clk(clk),
        .rst(rst),
        .sif(tim_sif)
    );

    // Divided pulses re-timed so outputs come from flip-flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_div_ff <= 1'b0;
            time_div_ff <= 1'b0;
        end else begin
            event_div_ff <= evt_sif.div_pulse; // RULE14
            time_div_ff <= tim_sif.div_pulse; // RULE14
        end
    end

    // Totals are taken one cycle after the closing timebase edge,
    // once the scaler has absorbed that last pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_count_ff <= '0;
            time_count_ff <= '0;
            count_valid_ff <= 1'b0;
        end else if (state_ff == mgis_pkg::ST_LATCH) begin
            // Latch wins over a same-cycle gate reset so a finished result is not lost
            event_count_ff <= evt_sif.count; // RULE9
            time_count_ff <= tim_sif.count; // RULE9
            count_valid_ff <= 1'b1;
        end else if (gate_rst) begin
            count_valid_ff <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_reset_sets_gates: assert property (gate_rst |=> event_gate_ff && time_gate_ff) // RULE5
        else $error("gate reset did not preset both gates");
    a_block_chan_a: assert property (!freq_mode |-> !evt_pulse) // RULE1
        else $error("channel A passed outside its mode");
    a_evt_gate_opens: assert property ( // RULE12
        state_ff == mgis_pkg::ST_ARMED && evt_pulse && gate_arm && !gate_rst |=> !event_gate_ff)
        else $error("event gate did not open on first armed pulse");
    a_time_gate_opens: assert property ( // RULE12
        tb_pulse && !event_gate_ff && !gate_rst |=> !time_gate_ff)
        else $error("time gate did not follow open event gate");
    a_evt_gate_closes: assert property ( // RULE13
        state_ff == mgis_pkg::ST_MEASURE && evt_pulse && !gate_arm && !gate_rst |=> event_gate_ff)
        else $error("event gate did not close after arm fell");
    a_time_on_tb_only: assert property (!tb_pulse && !gate_rst |=> $stable(time_gate_ff)) // RULE15
        else $error("time gate moved without a timebase edge");
    a_time_stays_high: assert property ( // RULE6
        event_gate_ff && time_gate_ff && !gate_rst |=> time_gate_ff)
        else $error("time gate fell while event gate high");
    a_evt_hold_count: assert property ( // RULE7 RULE8
        event_gate_ff && !interval_or_events_select && !gate_rst |=> $stable(evt_sif.count))
        else $error("event scaler counted while gate closed");
    a_tim_hold_count: assert property (time_gate_ff && !gate_rst |=> $stable(tim_sif.count)) // RULE7
        else $error("time scaler counted while gate closed");
    a_latch_counts: assert property ( // RULE9
        state_ff == mgis_pkg::ST_LATCH && !gate_rst |=> count_valid_ff && time_count_ff == $past(tim_sif.count))
        else $error("totals not delivered at gate end");
    a_tb_turnoff: assert property (ratio_or_totalize_select |=> !timebase_on_ff) // RULE10
        else $error("timebase left on in ratio mode");

    // Turn-off and blocking of unused signals
    a_ab_turnoff: assert property (external_ab_input_select |=> !channels_on_ff) // RULE10
        else $error("channels left on with external inputs selected");
    a_extc_turnoff: assert property (external_c_select |=> !timebase_on_ff) // RULE10
        else $error("timebase left on with external clock selected");
    a_block_timebase: assert property (!freq_mode |-> !tb_pulse) // RULE1 RULE4
        else $error("timebase passed outside its mode");
    a_chb_mux_pass: assert property (chb_edge |=> chb_mux_ff) // RULE3
        else $error("channel B edge did not pass its multiplexer");
    // Only a gated channel A pulse may move the event gate, never channel B
    a_evt_only_chan_a: assert property (!evt_pulse && !gate_rst |=> $stable(event_gate_ff)) // RULE2 RULE3
        else $error("event gate moved without a channel A pulse");

    // Gate sequencing
    a_idle_gates_high: assert property ( // RULE5
        state_ff == mgis_pkg::ST_IDLE |-> event_gate_ff && time_gate_ff)
        else $error("gate open while idle");
    a_arm_enters: assert property ( // RULE12
        state_ff == mgis_pkg::ST_IDLE && gate_arm && !gate_rst |=> state_ff == mgis_pkg::ST_ARMED)
        else $error("arm did not enter the armed phase");
    a_time_gate_closes: assert property ( // RULE13
        tb_pulse && event_gate_ff && !gate_rst |=> time_gate_ff)
        else $error("time gate did not follow closed event gate");
    a_close_to_latch: assert property ( // RULE13
        state_ff == mgis_pkg::ST_CLOSE && tb_pulse && !gate_rst |=> state_ff == mgis_pkg::ST_LATCH)
        else $error("closing timebase edge did not end the measurement");

    // Results and divided outputs; totals must not drift once delivered
    a_done_holds: assert property ( // RULE9
        state_ff == mgis_pkg::ST_DONE && !gate_rst |=> count_valid_ff && $stable(event_count_ff))
        else $error("totals changed after the measurement ended");
    a_evt_div_single: assert property (event_div_ff |=> !event_div_ff) // RULE14
        else $error("event divider pulse longer than one cycle");
    a_tim_div_single: assert property (time_div_ff |=> !time_div_ff) // RULE14
        else $error("time divider pulse longer than one cycle");

    c_gate_open: cover property (!event_gate_ff ##[1:50] !time_gate_ff);
    c_full_meas: cover property ($rose(count_valid_ff));
    c_ab_off: cover property (external_ab_input_select ##1 !channels_on_ff);
    c_evt_divided: cover property (event_div_ff);

endmodule // mgis_main_gate

// *** test/mgis_far_model.sv ***
// Far side of the main gate: arming control, signal sources and downstream scaler.
// Assumes one shared clk and the bench calling its tasks from a single process.
module mgis_far_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Gate control
    output logic gate_arm,
    output logic gate_rst,
    // Measured signals and timebase
    output logic channel_a_input_signal,
    output logic channel_b_input_signal,
    output logic timebase_in,
    // Divided pulses from the front stages
    input wire logic event_div_ff,
    input wire logic time_div_ff,
    output int ev_div_seen,
    output int tm_div_seen
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels at time zero
    initial begin
        gate_arm = 1'b0;
        gate_rst = 1'b0;
        channel_a_input_signal = 1'b0;
        channel_b_input_signal = 1'b0;
    end

    // Free-running timebase, one rising edge every two cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timebase_in <= 1'b0;
        end else begin
            timebase_in <= ~timebase_in;
        end
    end

    // Later scaler stages tally divided pulses; cleared per measurement
    always_ff @(posedge clk) begin
        if (gate_rst) begin
            ev_div_seen <= 0;
            tm_div_seen <= 0;
        end else begin
            ev_div_seen <= ev_div_seen + int'(event_div_ff === 1'b1);
            tm_div_seen <= tm_div_seen + int'(time_div_ff === 1'b1);
        end
    end

    // Gate reset precedes each new arm except in the rearm test
    task automatic reset_gates();
        @(posedge clk);
        gate_rst <= 1'b1;
        gate_arm <= 1'b0;
        @(posedge clk);
        gate_rst <= 1'b0;
    endtask

    // Arm level changes only on an edge
    task automatic arm(input logic lvl);
        @(posedge clk);
        gate_arm <= lvl;
    endtask

    // n pulses of one cycle, period p cycles; low sample between edges
    task automatic pulse(input logic on_a, input logic on_b, input int n, input int p);
        repeat (n) begin
            @(posedge clk);
            channel_a_input_signal <= on_a;
            channel_b_input_signal <= on_b;
            @(posedge clk);
            channel_a_input_signal <= 1'b0;
            channel_b_input_signal <= 1'b0;
            repeat (p - 2) @(posedge clk);
        end
    endtask
endmodule // mgis_far_model

// *** test/main_gate_input_selector_bench.sv ***
// Self-checking bench for the main gate: a table of mode rows, then hand tests.
// Assumes mgis_main_gate and mgis_far_model compiled before it.
module main_gate_input_selector_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst;
    logic rt_sel, ie_sel, ab_sel, c_sel;
    logic gate_arm, gate_rst, cha, chb, tb;
    logic event_gate_ff, time_gate_ff, event_div_ff, time_div_ff;
    logic [31:0] event_count_ff, time_count_ff;
    logic count_valid_ff, timebase_on_ff, channels_on_ff, chb_mux_ff;
    logic ev_opened, tm_opened, chb_seen;
    int fails = 0;
    int n_compared = 0;
    int d;
    int ev_seen, tm_seen;
    // Columns: ratio, interval, external_ab_input_select, ext_c, k, p, ev_open, tm_open, valid, tb_on, ch_on
    int rows [6][11] = '{
        '{0, 0, 0, 0, 5, 4, 1, 1, 1, 1, 1},
        '{0, 0, 0, 0, 45, 6, 1, 1, 1, 1, 1},
        '{1, 0, 0, 0, 5, 4, 0, 0, 0, 0, 1},
        '{0, 1, 0, 0, 5, 4, 0, 0, 0, 1, 1},
        '{0, 0, 1, 0, 5, 4, 0, 0, 0, 1, 0},
        '{0, 0, 0, 1, 5, 4, 1, 0, 0, 0, 1}};

    mgis_main_gate dut_u (.clk(clk), .rst(rst), .ratio_or_totalize_select(rt_sel),
        .interval_or_events_select(ie_sel), .external_ab_input_select(ab_sel),
        .external_c_select(c_sel), .gate_arm(gate_arm), .gate_rst(gate_rst),
        .channel_a_input_signal(cha), .channel_b_input_signal(chb), .timebase_in(tb),
        .event_gate_ff(event_gate_ff), .time_gate_ff(time_gate_ff), .event_div_ff(event_div_ff),
        .time_div_ff(time_div_ff), .event_count_ff(event_count_ff), .time_count_ff(time_count_ff),
        .count_valid_ff(count_valid_ff), .timebase_on_ff(timebase_on_ff),
        .channels_on_ff(channels_on_ff), .chb_mux_ff(chb_mux_ff));

    mgis_far_model far_u (.clk(clk), .rst(rst), .gate_arm(gate_arm), .gate_rst(gate_rst),
        .channel_a_input_signal(cha), .channel_b_input_signal(chb), .timebase_in(tb),
        .event_div_ff(event_div_ff), .time_div_ff(time_div_ff), .ev_div_seen(ev_seen), .tm_div_seen(tm_seen));

    always #20 clk = ~clk;

    // Sticky flags: did a gate open, did channel B pass its multiplexer
    always @(posedge clk) begin
        if (event_gate_ff === 1'b0) ev_opened = 1'b1;
        if (time_gate_ff === 1'b0) tm_opened = 1'b1;
        if (chb_mux_ff === 1'b1) chb_seen = 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Cleared off the edge so the tracker never races the clear
    task automatic clear_flags();
        #1;
        ev_opened = 1'b0;
        tm_opened = 1'b0;
        chb_seen = 1'b0;
    endtask

    // One gated run: k pulses with arm high, arm low, one closing pulse
    task automatic measure(input int k, input int p);
        far_u.reset_gates();
        clear_flags();
        far_u.arm(1'b1);
        repeat (3) @(posedge clk);
        #1 check({31'h0, event_gate_ff}, 32'h1);
        far_u.pulse(1'b1, 1'b1, k, p);
        far_u.arm(1'b0);
        far_u.pulse(1'b1, 1'b1, 1, p);
        repeat (8) @(posedge clk);
        #1;
    endtask

    // Watchdog: the whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end

    initial begin
        rst <= 1'b1;
        rt_sel <= 1'b0;
        ie_sel <= 1'b0;
        ab_sel <= 1'b0;
        c_sel <= 1'b0;
        ev_opened = 1'b0;
        tm_opened = 1'b0;
        chb_seen = 1'b0;
        repeat (16) @(posedge clk);
        #1 check({31'h0, event_gate_ff}, 32'h1);
        check({31'h0, time_gate_ff}, 32'h1);
        check({31'h0, count_valid_ff}, 32'h0);
        check(event_count_ff, 32'h0);
        @(posedge clk);
        rst <= 1'b0;
        $display("reset test done");
        // Mode rows
        for (int r = 0; r < 6; r++) begin
            @(posedge clk);
            rt_sel <= rows[r][0][0];
            ie_sel <= rows[r][1][0];
            ab_sel <= rows[r][2][0];
            c_sel <= rows[r][3][0];
            repeat (3) @(posedge clk);
            measure(rows[r][4], rows[r][5]);
            check({31'h0, ev_opened}, 32'(rows[r][6]));
            check({31'h0, tm_opened}, 32'(rows[r][7]));
            check({31'h0, count_valid_ff}, 32'(rows[r][8]));
            check({31'h0, timebase_on_ff}, 32'(rows[r][9]));
            check({31'h0, channels_on_ff}, 32'(rows[r][10]));
            if (rows[r][8] != 0) begin
                d = int'(time_count_ff) - (rows[r][4] * rows[r][5] + 1) / 2;
                check(event_count_ff, 32'(rows[r][4]));
                check({31'h0, d >= -1 && d <= 1}, 32'h1);
                check(32'(ev_seen), 32'(rows[r][4] / 20));
                check(32'(tm_seen), 32'((rows[r][4] * rows[r][5] + 1) / 2 / 20));
            end
            $display("row %0d done", r);
        end
        // Channel B alone in frequency mode never opens a gate
        @(posedge clk);
        c_sel <= 1'b0;
        repeat (3) @(posedge clk);
        far_u.reset_gates();
        clear_flags();
        far_u.arm(1'b1);
        far_u.pulse(1'b0, 1'b1, 3, 4);
        far_u.arm(1'b0);
        #1 check({31'h0, ev_opened}, 32'h0);
        check({31'h0, chb_seen}, 32'h1);
        $display("channel b test done");
        // Rearming without a gate reset is ignored and totals stand
        measure(3, 4);
        check({31'h0, count_valid_ff}, 32'h1);
        clear_flags();
        far_u.arm(1'b1);
        far_u.pulse(1'b1, 1'b0, 2, 4);
        far_u.arm(1'b0);
        #1 check({31'h0, ev_opened}, 32'h0);
        check(event_count_ff, 32'h3);
        $display("rearm test done");
        // Gate reset in mid-measurement closes both gates at once
        far_u.reset_gates();
        far_u.arm(1'b1);
        far_u.pulse(1'b1, 1'b0, 3, 4);
        #1 check({31'h0, event_gate_ff}, 32'h0);
        far_u.reset_gates();
        @(posedge clk);
        #1 check({31'h0, event_gate_ff}, 32'h1);
        check({31'h0, time_gate_ff}, 32'h1);
        check({31'h0, count_valid_ff}, 32'h0);
        check(event_count_ff, 32'h3);
        $display("abort test done");
        summarize();
    end
endmodule // main_gate_input_selector_bench
